// ==== shared/debug_break_map.vh ====
// Register map and field positions of the debug break unit.
// Assumes a 32-bit classic Wishbone slave decoding word addresses.
`ifndef DEBUG_BREAK_MAP_VH
`define DEBUG_BREAK_MAP_VH

`define DBG_ADDR_W          28
`define DBG_OFS_CTRL_LOW    28'h0078000
`define DBG_OFS_STAT_LOW    28'h0078002
`define DBG_OFS_IBA0        28'h0078004
`define DBG_OFS_IBA1        28'h0078008
`define DBG_OFS_DBA         28'h007800C
`define DBG_OFS_CTRL_HIGH   28'h0078010
`define DBG_OFS_STAT_HIGH   28'h0078012
`define DBG_OFS_IBA2        28'h0078014

`define DBG_CTL_MONITOR     0
`define DBG_CTL_STEP        1
`define DBG_CTL_IBE0        2
`define DBG_CTL_IBE1        3
`define DBG_CTL_DBE         4
`define DBG_CTL_RDBE        5
`define DBG_CTL_WRBE        6
`define DBG_CTL_IBE2        0

`define DBG_ST_HALT         0
`define DBG_ST_STEP         1
`define DBG_ST_IB0          2
`define DBG_ST_IB1          3
`define DBG_ST_DB           4
`define DBG_ST_RD           5
`define DBG_ST_WR           6
`define DBG_ST_BRK          7
`define DBG_ST_IB2          0

`define DBG_CTRL_RESET      8'h00
`define DBG_STAT_RESET      8'h00
`define DBG_ADDR_RESET      28'h0000000

`endif

// ==== rtl/break_compare.v ====
// One break address comparator with enable.
// Assumes address and register on the same clock; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module break_compare #(
  parameter AW = 28,
  parameter IGNORE_LSB = 1
) (
  input  wire [AW-1:0] breakAddr,
  input  wire [AW-1:0] busAddr,
  input  wire          enable,
  output wire          hit
);
  wire [AW-1:0] mask;
  // Instruction compares drop bit 0; data compares need every bit
  assign mask = IGNORE_LSB ? {{(AW-1){1'b1}}, 1'b0} : {AW{1'b1}};
  assign hit  = enable && (((breakAddr ^ busAddr) & mask) == {AW{1'b0}});
endmodule // break_compare
`default_nettype wire

// ==== rtl/debug_break_unit.v ====
// Debug break unit: control, cause status, address comparators, masks.
// Assumes CPU pipeline strobes on clk; halt request pin is asynchronous.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "debug_break_map.vh"
`default_nettype none
module debug_break_unit #(
  parameter AW = `DBG_ADDR_W
) (
  input  wire          clk,
  input  wire          arst_n,
  // Classic Wishbone slave
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [31:0]   wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  output wire          wb_err_o,
  // CPU fetch side
  input  wire          fetchValid,
  input  wire [31:0]   fetchPc,
  input  wire          softBreakExec,
  // CPU data side, one pulse when an access completes
  input  wire          dataAccessDone,
  input  wire          dataAccessWrite,
  input  wire [31:0]   dataAccessAddr,
  // Mode changes from the CPU
  input  wire          monitorReturn,
  input  wire          instrRetired,
  // Asynchronous pin
  input  wire          external_halt_request_n,
  // Other exception requests from the CPU
  input  wire          excReset,
  input  wire          excAddrError,
  input  wire          excDivZero,
  input  wire          excSoftInt,
  input  wire          excIrq,
  input  wire          excNmi,
  input  wire          excOther,
  // Outputs to the CPU
  output reg           debugException,
  output wire          in_monitor_flag,
  output wire          excAllowed,
  output wire          excDebugPath,
  output wire          excMasked
);
  reg  [7:0]    ctrlLow_q;
  reg           ctrlHigh_q;
  reg  [4:0]    ctrlHighFix_q;
  reg  [7:0]    statLow_q;
  reg           statHigh_q;
  reg  [AW-1:0] iba0_q;
  reg  [AW-1:0] iba1_q;
  reg  [AW-1:0] iba2_q;
  reg  [AW-1:0] dba_q;
  reg           monitor_q;
  reg           postReturn_q;
  reg           haltSync1_q;
  reg           haltSync2_q;
  reg           haltPrev_q;
  reg           dataBreakPend_q;
  reg           dataBreakRd_q;
  reg           dataBreakWr_q;

  wire          reqValid;
  wire          wrOk;
  wire [AW-1:0] wordAddr;
  wire          hitCtrl;
  wire          hitStat;
  wire          hitIba0;
  wire          hitIba1;
  wire          hitDba;
  wire          hitCtrlH;
  wire          hitStatH;
  wire          hitIba2;
  wire          mapped;
  wire [2:0]    ibHit;
  wire [2:0]    ibEnable;
  wire [AW-1:0] ibAddr [0:2];
  wire          dbMatch;
  wire          userMode;
  wire          haltFall;
  wire          stepFactor;
  wire          rdFactor;
  wire          wrFactor;
  wire          anyFactor;

  assign in_monitor_flag = monitor_q;
  assign userMode        = !monitor_q;

  // Bus decode on word addresses; byte lanes select the halfword registers
  assign reqValid = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wordAddr = {wb_adr_i[AW-1:2], 2'b00};
  assign hitCtrl  = (wordAddr == `DBG_OFS_CTRL_LOW);
  assign hitIba0  = (wordAddr == `DBG_OFS_IBA0);
  assign hitIba1  = (wordAddr == `DBG_OFS_IBA1);
  assign hitDba   = (wordAddr == `DBG_OFS_DBA);
  assign hitCtrlH = (wordAddr == `DBG_OFS_CTRL_HIGH);
  assign hitIba2  = (wordAddr == `DBG_OFS_IBA2);
  // Status bytes share the word of their control byte, on lane 2
  assign hitStat  = hitCtrl;
  assign hitStatH = hitCtrlH;
  assign mapped   = hitCtrl | hitIba0 | hitIba1 | hitDba | hitCtrlH | hitIba2;
  assign wb_err_o = 1'b0;
  assign wrOk     = reqValid && wb_we_i && monitor_q;

  // Instruction comparators, one per breakpoint
  assign ibEnable = {ctrlHigh_q, ctrlLow_q[`DBG_CTL_IBE1], ctrlLow_q[`DBG_CTL_IBE0]};
  assign ibAddr[0] = iba0_q;
  assign ibAddr[1] = iba1_q;
  assign ibAddr[2] = iba2_q;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : gIbCmp
      break_compare #(.AW(AW), .IGNORE_LSB(1)) uCmp (
        .breakAddr (ibAddr[gi]),
        .busAddr   (fetchPc[AW-1:0]),
        .enable    (ibEnable[gi] && fetchValid && userMode),
        .hit       (ibHit[gi])
      );
    end
  endgenerate

  // Data comparator needs an exact base match
  break_compare #(.AW(AW), .IGNORE_LSB(0)) uDataCmp (
    .breakAddr (dba_q),
    .busAddr   (dataAccessAddr[AW-1:0]),
    .enable    (ctrlLow_q[`DBG_CTL_DBE] && dataAccessDone && userMode),
    .hit       (dbMatch)
  );
  // Neither qualifier set leaves both terms low
  assign rdFactor = dbMatch && !dataAccessWrite && ctrlLow_q[`DBG_CTL_RDBE];
  assign wrFactor = dbMatch && dataAccessWrite && ctrlLow_q[`DBG_CTL_WRBE];

  assign stepFactor = ctrlLow_q[`DBG_CTL_STEP] && fetchValid && userMode;
  assign haltFall   = haltPrev_q && !haltSync2_q;
  // Data break is reported after the access, with the next fetch
  assign anyFactor  = (fetchValid && userMode && (stepFactor | (|ibHit) | dataBreakPend_q))
                      | (softBreakExec && userMode) | haltFall;

  // Exception gating for the CPU
  assign excMasked    = excOther && (monitor_q || postReturn_q);
  assign excDebugPath = 1'b0;
  assign excAllowed   = excReset | excAddrError | excIrq | excNmi
                        // Return window is left stale on re-entry; debug mode overrides it
                        | ((excDivZero | excSoftInt) && (monitor_q || !postReturn_q))
                        | (excOther && !monitor_q && !postReturn_q);

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      haltSync1_q <= 1'b1;
      haltSync2_q <= 1'b1;
      haltPrev_q  <= 1'b1;
    end
    else
    begin
      haltSync1_q <= external_halt_request_n;
      haltSync2_q <= haltSync1_q;
      haltPrev_q  <= haltSync2_q;
    end
  end

  // Data break held until the next fetch boundary
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dataBreakPend_q <= 1'b0;
      dataBreakRd_q   <= 1'b0;
      dataBreakWr_q   <= 1'b0;
    end
    else if (monitor_q)
    begin
      dataBreakPend_q <= 1'b0;
      dataBreakRd_q   <= 1'b0;
      dataBreakWr_q   <= 1'b0;
    end
    else
    begin
      if (rdFactor | wrFactor)
        dataBreakPend_q <= 1'b1;
      else if (fetchValid)
        dataBreakPend_q <= 1'b0;
      if (rdFactor)
        dataBreakRd_q <= 1'b1;
      else if (fetchValid && !wrFactor)
        dataBreakRd_q <= 1'b0;
      if (wrFactor)
        dataBreakWr_q <= 1'b1;
      else if (fetchValid && !rdFactor)
        dataBreakWr_q <= 1'b0;
    end
  end

  // Mode tracking and single exception pulse
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      monitor_q      <= 1'b0;
      postReturn_q   <= 1'b0;
      debugException <= 1'b0;
    end
    else
    begin
      debugException <= anyFactor && !monitor_q;
      if (anyFactor && !monitor_q)
        monitor_q <= 1'b1;
      else if (monitorReturn)
        monitor_q <= 1'b0;
      if (monitorReturn && monitor_q)
        postReturn_q <= 1'b1;
      else if (instrRetired)
        postReturn_q <= 1'b0;
    end
  end

  // Registers; event sets win over software writes
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrlLow_q     <= `DBG_CTRL_RESET;
      ctrlHigh_q    <= 1'b0;
      ctrlHighFix_q <= 5'h00;
      statLow_q     <= `DBG_STAT_RESET;
      statHigh_q    <= 1'b0;
      iba0_q        <= `DBG_ADDR_RESET;
      iba1_q        <= `DBG_ADDR_RESET;
      iba2_q        <= `DBG_ADDR_RESET;
      dba_q         <= `DBG_ADDR_RESET;
    end
    else
    begin
      if (wrOk && hitCtrl && wb_sel_i[0])
        ctrlLow_q <= {1'b0, wb_dat_i[6:1], 1'b0};
      if (wrOk && hitCtrlH && wb_sel_i[0])
      begin
        ctrlHigh_q    <= wb_dat_i[`DBG_CTL_IBE2];
        ctrlHighFix_q <= wb_dat_i[5:1];
      end
      if (wrOk && hitIba0)
      begin
        if (wb_sel_i[0]) iba0_q[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) iba0_q[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) iba0_q[23:16] <= wb_dat_i[23:16];
        if (wb_sel_i[3]) iba0_q[27:24] <= wb_dat_i[27:24];
      end
      if (wrOk && hitIba1)
      begin
        if (wb_sel_i[0]) iba1_q[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) iba1_q[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) iba1_q[23:16] <= wb_dat_i[23:16];
        if (wb_sel_i[3]) iba1_q[27:24] <= wb_dat_i[27:24];
      end
      if (wrOk && hitIba2)
      begin
        if (wb_sel_i[0]) iba2_q[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) iba2_q[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) iba2_q[23:16] <= wb_dat_i[23:16];
        if (wb_sel_i[3]) iba2_q[27:24] <= wb_dat_i[27:24];
      end
      if (wrOk && hitDba)
      begin
        if (wb_sel_i[0]) dba_q[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) dba_q[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) dba_q[23:16] <= wb_dat_i[23:16];
        if (wb_sel_i[3]) dba_q[27:24] <= wb_dat_i[27:24];
      end
      // Flags persist until overwritten in debug mode
      statLow_q <= ((wrOk && hitStat && wb_sel_i[2]) ? wb_dat_i[23:16] : statLow_q)
        | {softBreakExec && userMode,
           dataBreakWr_q && fetchValid && userMode,
           dataBreakRd_q && fetchValid && userMode,
           dataBreakPend_q && fetchValid && userMode,
           ibHit[1], ibHit[0], stepFactor,
           haltFall};
      statHigh_q <= ((wrOk && hitStatH && wb_sel_i[2]) ? wb_dat_i[16] : statHigh_q)
        | ibHit[2];
    end
  end

  // Single-wait answer: ack one cycle after the strobe
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= reqValid;
      if (reqValid && !wb_we_i)
      begin
        if (hitCtrl)
          wb_dat_o <= {8'h00, statLow_q, 8'h00, ctrlLow_q[7:1], monitor_q};
        else if (hitCtrlH)
          wb_dat_o <= {15'h0000, statHigh_q, 10'h000, ctrlHighFix_q, ctrlHigh_q};
        else if (hitIba0)
          wb_dat_o <= {4'h0, iba0_q};
        else if (hitIba1)
          wb_dat_o <= {4'h0, iba1_q};
        else if (hitIba2)
          wb_dat_o <= {4'h0, iba2_q};
        else if (hitDba)
          wb_dat_o <= {4'h0, dba_q};
        else
          wb_dat_o <= 32'h00000000;
      end
    end
  end
endmodule // debug_break_unit
`default_nettype wire

// ==== verif/debug_break_unit_sva.sv ====
// Port-level checks of the debug break unit.
// Assumes CPU strobes arrive as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module debug_break_unit_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic fetchValid,
  input wire logic softBreakExec,
  input wire logic excAddrError,
  input wire logic excDivZero,
  input wire logic excSoftInt,
  input wire logic excOther,
  input wire logic external_halt_request_n,
  input wire logic debugException,
  input wire logic in_monitor_flag,
  input wire logic excAllowed,
  input wire logic excDebugPath,
  input wire logic excMasked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not one pulse");
  user_only_a: assert property (debugException |-> $rose(in_monitor_flag))
    else $error("exception without mode entry");
  one_exc_a: assert property (debugException |=> !debugException)
    else $error("exception pulse too long");
  soft_break_a: assert property (fetchValid && softBreakExec && !in_monitor_flag
    |=> debugException && in_monitor_flag)
    else $error("soft break missed");
  mon_suppress_a: assert property (in_monitor_flag && excOther |-> excMasked)
    else $error("exception not suppressed");
  mon_ordinary_a: assert property (in_monitor_flag && (excAddrError || excDivZero || excSoftInt)
    |-> excAllowed && !excDebugPath)
    else $error("ordinary exception blocked");
  return_mask_a: assert property ($fell(in_monitor_flag) && excOther |-> excMasked)
    else $error("return window not masked");
  halt_enter_a: assert property ($fell(external_halt_request_n) && !in_monitor_flag
    |-> ##[1:8] in_monitor_flag)
    else $error("halt request ignored");
  cover property (debugException && $past(fetchValid));
  cover property ($fell(in_monitor_flag) && excOther);
  cover property (wb_ack_o && wb_we_i);
endmodule // debug_break_unit_sva
bind debug_break_unit debug_break_unit_sva debug_break_unit_sva_i (.clk, .arst_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_ack_o, .fetchValid, .softBreakExec, .excAddrError, .excDivZero,
  .excSoftInt, .excOther, .external_halt_request_n, .debugException, .in_monitor_flag,
  .excAllowed, .excDebugPath, .excMasked);
`default_nettype wire

// ==== verif/monitor_model.sv ====
// Debug monitor side: issues classic register accesses, each held until ack.
// Assumes a slave that raises ack once per request.
`timescale 1ns/1ps
`default_nettype none
module monitor_model (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output var  logic        cyc,
  output var  logic        stb,
  output var  logic        we,
  output var  logic [31:0] adr,
  output var  logic [31:0] dat,
  output var  logic [3:0]  sel
);
  initial
  begin
    {cyc, stb, we, adr, dat, sel} = '0;
  end
  // Whole word per access; no wait count assumed
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, 4'hF};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released data never repeats the last value
    dat <= ~d;
  endtask
endmodule // monitor_model
`default_nettype wire

// ==== verif/debug_break_unit_test.sv ====
// Self-checking bench for the debug break unit.
// Assumes the monitor model carries every register access.
`timescale 1ns/1ps
`default_nettype none
module debug_break_unit_test;
  localparam logic [31:0] LO = 32'h0007_8000;
  localparam logic [31:0] HI = 32'h0007_8010;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        haltN = 1'b1;
  logic [5:0]  ctl = 6'h00;
  logic [6:0]  exc = 7'h00;
  logic [31:0] cpuAddr = 32'h0;
  int          badCount = 0;
  int          totalChecks = 0;
  int          cycles = 0;
  logic [31:0] adrs [4] = '{32'h0007_8004, 32'h0007_8008, 32'h0007_800C, 32'h0007_8014};
  wire         cyc, stb, we, ack, err, dbgExc, inMon, allowed, dbgPath, masked;
  wire [31:0]  adr, wdat, rdat;
  wire [3:0]   sel;
  debug_break_unit debug_break_unit_i (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .fetchValid(ctl[5]), .fetchPc(cpuAddr),
    .softBreakExec(ctl[4]), .dataAccessDone(ctl[3]), .dataAccessWrite(ctl[2]),
    .dataAccessAddr(cpuAddr), .monitorReturn(ctl[1]), .instrRetired(ctl[0]),
    .external_halt_request_n(haltN), .excReset(exc[6]), .excAddrError(exc[5]),
    .excDivZero(exc[4]), .excSoftInt(exc[3]), .excIrq(exc[2]), .excNmi(exc[1]),
    .excOther(exc[0]), .debugException(dbgExc), .in_monitor_flag(inMon),
    .excAllowed(allowed), .excDebugPath(dbgPath), .excMasked(masked));
  monitor_model monitor_model_i (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .dat(wdat), .sel(sel));
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      badCount++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    monitor_model_i.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    monitor_model_i.xfer(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  // Bits: fetch, soft break, access, write, return, retire
  task automatic cpu(input logic [5:0] c, input logic [31:0] a);
    @(posedge clk);
    ctl <= c;
    cpuAddr <= a;
    @(posedge clk);
    ctl <= 6'h00;
    #1;
  endtask
  task automatic setExc(input logic [6:0] v);
    @(posedge clk);
    exc <= v;
    #1;
  endtask
  // Status cleared by the control write; soft break re-enters after a miss
  task automatic trial(input logic [7:0] c, input logic [5:0] acc, input logic [31:0] da,
                       input logic [31:0] pc, input logic e, input logic [31:0] sa,
                       input logic [31:0] se);
    wr(LO, {24'h0, c});
    wr(HI, 32'h0000_000F);
    cpu(6'h02, 32'h0);
    if (acc != 6'h00) cpu(acc, da);
    cpu(6'h20, pc);
    check(dbgExc, e);
    if (e) rd(sa, se);
    else cpu(6'h30, pc);
  endtask
  task automatic testRegs;
    rd(LO, 32'h0);
    rd(HI, 32'h0);
    wr(adrs[0], 32'h0000_0123);
    rd(adrs[0], 32'h0);
    cpu(6'h30, 32'h0);
    rd(LO, 32'h0080_0001);
    for (int i = 0; i < 4; i++)
    begin
      wr(adrs[i], 32'hFFFF_FFFF);
      rd(adrs[i], 32'h0FFF_FFFF);
    end
    rd(LO, 32'h0080_0001);
    rd(32'h0007_801C, 32'h0);
    check(err, 1'b0);
    $display("registers test done");
  endtask
  task automatic testBreaks;
    wr(adrs[0], 32'h0000_0100);
    wr(adrs[1], 32'h0000_0200);
    wr(adrs[2], 32'h0000_0400);
    wr(adrs[3], 32'h0000_0301);
    trial(8'h0C, 6'h00, 32'h0, 32'h1000_0101, 1'b1, LO, 32'h0004_000D);
    trial(8'h0C, 6'h00, 32'h0, 32'h0000_0200, 1'b1, LO, 32'h0008_000D);
    trial(8'h00, 6'h00, 32'h0, 32'h0000_0300, 1'b1, HI, 32'h0001_000F);
    trial(8'h00, 6'h00, 32'h0, 32'h0000_0100, 1'b0, LO, 32'h0);
    trial(8'h06, 6'h00, 32'h0, 32'h0000_0100, 1'b1, LO, 32'h0006_0007);
    trial(8'h30, 6'h08, 32'h402, 32'h0000_0500, 1'b0, LO, 32'h0);
    trial(8'h30, 6'h08, 32'h400, 32'h0000_0500, 1'b1, LO, 32'h0030_0031);
    trial(8'h50, 6'h0C, 32'h400, 32'h0000_0500, 1'b1, LO, 32'h0050_0051);
    trial(8'h10, 6'h08, 32'h400, 32'h0000_0500, 1'b0, LO, 32'h0);
    trial(8'h50, 6'h08, 32'h400, 32'h0000_0500, 1'b0, LO, 32'h0);
    wr(LO, 32'h0000_000C);
    cpu(6'h20, 32'h0000_0100);
    check(dbgExc, 1'b0);
    $display("break test done");
  endtask
  task automatic testHalt;
    wr(LO, 32'h0);
    cpu(6'h02, 32'h0);
    @(posedge clk);
    haltN <= 1'b0;
    repeat (10) if (inMon !== 1'b1) @(posedge clk);
    haltN <= 1'b1;
    #1;
    check(inMon, 1'b1);
    rd(LO, 32'h0001_0001);
    $display("halt test done");
  endtask
  task automatic testMasks;
    setExc(7'h01);
    check(masked, 1'b1);
    setExc(7'h10);
    check(allowed, 1'b1);
    check(dbgPath, 1'b0);
    setExc(7'h08);
    check(allowed, 1'b1);
    setExc(7'h01);
    cpu(6'h02, 32'h0);
    check(masked, 1'b1);
    setExc(7'h08);
    check(allowed, 1'b0);
    setExc(7'h46);
    check(allowed, 1'b1);
    setExc(7'h01);
    cpu(6'h01, 32'h0);
    check(masked, 1'b0);
    setExc(7'h20);
    check(allowed, 1'b1);
    setExc(7'h00);
    $display("mask test done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    testRegs();
    testBreaks();
    testHalt();
    testMasks();
    conclude();
  end
endmodule // debug_break_unit_test
`default_nettype wire
